// [rtl/lcre_pkg.sv]
package lcre_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OFF_PHASE_A_POWER_GAIN    = 16'h4399;
  localparam logic [15:0] OFF_PHASE_B_POWER_GAIN    = 16'h439A;
  localparam logic [15:0] OFF_PHASE_C_POWER_GAIN    = 16'h439B;
  localparam logic [15:0] OFF_PHASE_A_TOTAL_VAR_OFS = 16'h439F;
  localparam logic [15:0] OFF_PHASE_B_TOTAL_VAR_OFS = 16'h43A0;
  localparam logic [15:0] OFF_PHASE_C_TOTAL_VAR_OFS = 16'h43A1;
  localparam logic [15:0] OFF_PHASE_A_FUND_VAR_OFS  = 16'h43A6;
  localparam logic [15:0] OFF_PHASE_B_FUND_VAR_OFS  = 16'h43A7;
  localparam logic [15:0] OFF_PHASE_C_FUND_VAR_OFS  = 16'h43A8;
  localparam logic [15:0] OFF_PHASE_A_INST_VAR      = 16'hE51B;
  localparam logic [15:0] OFF_PHASE_B_INST_VAR      = 16'hE51C;
  localparam logic [15:0] OFF_PHASE_C_INST_VAR      = 16'hE51D;
  localparam logic [15:0] OFF_HALF_CYCLE_COUNT      = 16'hE60C;
  localparam logic [15:0] OFF_COMPENSATION_MODE     = 16'hE60E;
  localparam logic [15:0] OFF_CYCLE_ACCUM_MODE      = 16'hE702;
  localparam logic [15:0] OFF_FIRST_STATUS          = 16'hE502;
  localparam logic [15:0] OFF_FIRST_MASK            = 16'hE50A;
  localparam logic [15:0] OFF_ACCUM_MODE            = 16'hE701;
  localparam logic [15:0] OFF_TOTAL_ACTIVE_ENERGY   = 16'hE400;
  localparam logic [15:0] OFF_FUND_ACTIVE_ENERGY    = 16'hE403;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LINE_ACTIVE_ENABLE_BIT = 0;
  localparam int CROSSING_SEL_LSB       = 3;
  localparam int CLEAR_ON_READ_BIT      = 6;
  localparam int CYCLE_DONE_BIT         = 5;
  localparam int CONSUMPTION_SEL_LSB    = 4;
  localparam logic [1:0] CONSUMPTION_SELECT_3WIRE   = 2'h1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_HALF_CYCLE_COUNT  = 16'hFFFF;
  localparam logic [15:0] RST_COMPENSATION_MODE = 16'h01FF;
  localparam logic [7:0]  RST_CYCLE_ACCUM_MODE  = 8'h78;
  localparam logic [23:0] RST_GAIN_OFFSET       = 24'h00_0000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int ACCUM_HZ        = 1_024_000;
  localparam int ACCUM_DIV_TICKS = CLK_HZ / ACCUM_HZ;
  localparam int FUND_SETTLE_63_MS  = 375;
  localparam int FUND_SETTLE_100_MS = 875;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lcre_req_t;

  typedef struct packed {
    logic signed [23:0] volt;
    logic signed [23:0] curr;
    logic signed [23:0] curr_q;
    logic               zero_cross;
  } lcre_phase_t;

  typedef enum logic [1:0] {
    LC_FREE,
    LC_COUNT,
    LC_LATCH
  } lcre_state_t;

endpackage

// [rtl/lcre_regfile.sv]
`timescale 1ns/100ps
module lcre_regfile
  import lcre_pkg::*;
#(
  parameter int DEPTH = 9,
  parameter int WIDTH = 24
) (
  // Clock and reset.
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // Write port.
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port.
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data,
  // All entries, for the datapath.
  output logic      [DEPTH*WIDTH-1:0]   all_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge core_clk) begin
        if (srst) begin
          mem_reg[g] <= WIDTH'(RST_GAIN_OFFSET);
        end else if (wr_en && wr_idx == g) begin
          mem_reg[g] <= wr_data;
        end
      end
      assign all_data[g*WIDTH +: WIDTH] = mem_reg[g];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule // lcre_regfile

// [rtl/lcre_phase_power.sv]
`timescale 1ns/100ps
module lcre_phase_power
  import lcre_pkg::*;
(
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               srst,
  // Phase samples.
  input  wire lcre_phase_t        samp,
  input  wire logic               force_zero,
  // Calibration.
  input  wire logic signed [23:0] gain,
  input  wire logic signed [23:0] total_ofs,
  input  wire logic signed [23:0] fund_ofs,
  // Results.
  output logic signed [23:0]      inst_var,
  output logic signed [23:0]      fund_var,
  output logic signed [23:0]      act_pow
);

  logic signed [23:0] i_used;
  logic signed [23:0] iq_used;
  logic signed [47:0] q_prod;
  logic signed [47:0] p_prod;
  logic signed [47:0] q_gain;
  logic signed [47:0] p_gain;
  logic signed [23:0] q_mul;
  logic signed [23:0] p_mul;

  assign i_used  = force_zero ? 24'sh00_0000 : samp.curr;
  assign iq_used = force_zero ? 24'sh00_0000 : samp.curr_q;
  assign q_prod  = samp.volt * iq_used;
  assign p_prod  = samp.volt * i_used;
  assign q_mul   = q_prod[46:23];
  assign p_mul   = p_prod[46:23];
  assign q_gain  = q_mul * gain;
  assign p_gain  = p_mul * gain;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      inst_var <= '0;
      fund_var <= '0;
      act_pow  <= '0;
    end else begin
      inst_var <= q_mul + q_gain[46:23] + total_ofs;
      fund_var <= q_mul + q_gain[46:23] + fund_ofs;
      act_pow  <= p_mul + p_gain[46:23];
    end
  end

endmodule // lcre_phase_power

// [rtl/lcre_line_cycle.sv]
`timescale 1ns/100ps
// Operation
// - Three-wire mode zeroes Phase B current.
// - Three-wire Phase B rms holds A-C voltage.
// - Line mode latches energy after count reached.
// - Mode bit 0 enables line cycle accumulation.
// - Host keeps clear-on-read off; read leaves accumulation intact.
// - Only selected phases' crossings are counted.
// - Half-cycle count is 16-bit unsigned.
// - Crossing counter always runs regardless mode.
// - Count write in line mode restarts counter.
// - Period end sets flag, masked interrupt low.
// - Writing one clears flag, releases interrupt.
// - Line mode shares normal energy path.
// - Reactive power uses 90 degree shifted current.
// - Three consecutive instantaneous reactive power registers.
// - Instantaneous reactive registers readable over port.
// - Fundamental reactive result settles within limits.
// - Per-phase gain scales all powers.
// - Separate signed total and fundamental offsets.
// - Offset LSB equals multiplier output LSB.
// - Offsets sign-extend to 28, pad four zeros.
// - Normal mode copies accumulators on access.
// - Clear-on-read zeroes register after read.
module lcre_line_cycle
  import lcre_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int ACC_W   = 32
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Register port.
  input  wire lcre_req_t   req,
  output logic [31:0]      rdata,
  output logic             rvalid,
  // Phase samples, A, B, C.
  input  wire lcre_phase_t phase_a,
  input  wire lcre_phase_t phase_b,
  input  wire lcre_phase_t phase_c,
  input  wire logic [23:0] line_ac_rms,
  input  wire logic [23:0] phase_b_rms_in,
  // Outputs.
  output logic [23:0]      phase_b_voltage_rms,
  output logic             interrupt_pin_0_n
);

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [COUNT_W-1:0] half_cycle_count_reg;
  logic [15:0]        compensation_mode_reg;
  logic [7:0]         cycle_accumulation_mode_reg;
  logic [15:0]        first_interrupt_mask_reg;
  logic [15:0]        accum_mode_reg;
  logic               cycle_done_flag_reg;

  logic       wr_hcc;
  logic       wr_cmp;
  logic       wr_lcm;
  logic       wr_msk;
  logic       wr_acm;
  logic       wr_sts;
  logic       line_active_enable;
  logic       clear_on_read;
  logic [2:0] crossing_phase_select;
  logic [1:0] consumption_select;
  logic       three_wire;

  assign wr_hcc = req.wr && req.addr == OFF_HALF_CYCLE_COUNT;
  assign wr_cmp = req.wr && req.addr == OFF_COMPENSATION_MODE;
  assign wr_lcm = req.wr && req.addr == OFF_CYCLE_ACCUM_MODE;
  assign wr_msk = req.wr && req.addr == OFF_FIRST_MASK;
  assign wr_acm = req.wr && req.addr == OFF_ACCUM_MODE;
  assign wr_sts = req.wr && req.addr == OFF_FIRST_STATUS;

  assign line_active_enable    = cycle_accumulation_mode_reg[LINE_ACTIVE_ENABLE_BIT];
  assign clear_on_read         = cycle_accumulation_mode_reg[CLEAR_ON_READ_BIT];
  assign crossing_phase_select = cycle_accumulation_mode_reg[CROSSING_SEL_LSB +: 3];
  assign consumption_select    = accum_mode_reg[CONSUMPTION_SEL_LSB +: 2];
  assign three_wire            = consumption_select == CONSUMPTION_SELECT_3WIRE;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      half_cycle_count_reg        <= RST_HALF_CYCLE_COUNT;
      compensation_mode_reg       <= RST_COMPENSATION_MODE;
      cycle_accumulation_mode_reg <= RST_CYCLE_ACCUM_MODE;
      first_interrupt_mask_reg    <= 16'h0000;
      accum_mode_reg              <= 16'h0000;
    end else begin
      if (wr_hcc) half_cycle_count_reg <= req.wdata[COUNT_W-1:0];
      if (wr_cmp) compensation_mode_reg <= req.wdata[15:0];
      if (wr_lcm) cycle_accumulation_mode_reg <= req.wdata[7:0];
      if (wr_msk) first_interrupt_mask_reg <= req.wdata[15:0];
      if (wr_acm) accum_mode_reg <= req.wdata[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Calibration storage
  // ---------------------------------------------------------------------------
  logic       cal_wr;
  logic [3:0] cal_wr_idx;
  logic [3:0] cal_rd_idx;
  logic       cal_hit;
  logic [23:0] cal_rdata;
  logic [9*24-1:0] cal_all;

  assign cal_hit = (req.addr >= OFF_PHASE_A_POWER_GAIN && req.addr <= OFF_PHASE_C_POWER_GAIN)
                || (req.addr >= OFF_PHASE_A_TOTAL_VAR_OFS && req.addr <= OFF_PHASE_C_TOTAL_VAR_OFS)
                || (req.addr >= OFF_PHASE_A_FUND_VAR_OFS && req.addr <= OFF_PHASE_C_FUND_VAR_OFS);
  assign cal_rd_idx = (req.addr <= OFF_PHASE_C_POWER_GAIN)    ? 4'(req.addr - OFF_PHASE_A_POWER_GAIN) :
                      (req.addr <= OFF_PHASE_C_TOTAL_VAR_OFS) ? 4'(req.addr - OFF_PHASE_A_TOTAL_VAR_OFS + 16'h0003) :
                                                                4'(req.addr - OFF_PHASE_A_FUND_VAR_OFS + 16'h0006);
  assign cal_wr_idx = cal_rd_idx;
  assign cal_wr     = req.wr && cal_hit;

  lcre_regfile #(
    .DEPTH (9),
    .WIDTH (24)
  ) u_cal (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (cal_wr),
    .wr_idx   (cal_wr_idx),
    .wr_data  (req.wdata[23:0]),
    .rd_idx   (cal_rd_idx),
    .rd_data  (cal_rdata),
    .all_data (cal_all)
  );

  // ---------------------------------------------------------------------------
  // Per-phase power
  // ---------------------------------------------------------------------------
  lcre_phase_t       samp [3];
  logic signed [23:0] inst_var [3];
  logic signed [23:0] fund_var [3];
  logic signed [23:0] act_pow [3];

  assign samp[0] = phase_a;
  assign samp[1] = phase_b;
  assign samp[2] = phase_c;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_ph
      lcre_phase_power u_pw (
        .core_clk   (core_clk),
        .srst       (srst),
        .samp       (samp[p]),
        .force_zero (p == 1 && three_wire),
        .gain       (cal_all[p*24 +: 24]),
        .total_ofs  (cal_all[(p+3)*24 +: 24]),
        .fund_ofs   (cal_all[(p+6)*24 +: 24]),
        .inst_var   (inst_var[p]),
        .fund_var   (fund_var[p]),
        .act_pow    (act_pow[p])
      );
    end
  endgenerate

  assign phase_b_voltage_rms = three_wire ? line_ac_rms : phase_b_rms_in;

  // ---------------------------------------------------------------------------
  // Accumulation rate divider
  // ---------------------------------------------------------------------------
  logic [3:0] div_reg;
  logic       acc_tick;

  assign acc_tick = div_reg == 4'(ACCUM_DIV_TICKS - 1);

  always_ff @(posedge core_clk) begin
    if (srst || acc_tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Zero-crossing counter
  // ---------------------------------------------------------------------------
  logic [COUNT_W-1:0] zc_cnt_reg;
  logic [2:0]         zc_raw;
  logic               zc_hit;
  logic [1:0]         zc_num;
  logic               period_end;
  lcre_state_t        lc_state_reg;

  assign zc_raw = {phase_c.zero_cross, phase_b.zero_cross, phase_a.zero_cross} & crossing_phase_select;
  assign zc_num = 2'(zc_raw[0]) + 2'(zc_raw[1]) + 2'(zc_raw[2]);
  assign zc_hit = |zc_raw;
  assign period_end = zc_hit && ({14'h0000, zc_num} >= zc_cnt_reg);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      zc_cnt_reg <= RST_HALF_CYCLE_COUNT;
    end else if (wr_hcc && line_active_enable) begin
      zc_cnt_reg <= req.wdata[COUNT_W-1:0];
    end else if (period_end) begin
      zc_cnt_reg <= half_cycle_count_reg;
    end else if (zc_hit) begin
      zc_cnt_reg <= zc_cnt_reg - COUNT_W'(zc_num);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lc_state_reg <= LC_FREE;
    end else begin
      case (lc_state_reg)
        LC_FREE:  lc_state_reg <= line_active_enable ? LC_COUNT : LC_FREE;
        LC_COUNT: lc_state_reg <= !line_active_enable ? LC_FREE : (period_end ? LC_LATCH : LC_COUNT);
        LC_LATCH: lc_state_reg <= line_active_enable ? LC_COUNT : LC_FREE;
        default:  lc_state_reg <= LC_FREE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Active energy accumulators
  // ---------------------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_tot_reg [3];
  logic signed [ACC_W-1:0] acc_fnd_reg [3];
  logic signed [ACC_W-1:0] out_tot_reg [3];
  logic signed [ACC_W-1:0] out_fnd_reg [3];
  logic                    lc_latch;
  logic [2:0]              rd_tot;
  logic [2:0]              rd_fnd;

  assign lc_latch = lc_state_reg != LC_FREE && line_active_enable && period_end;

  generate
    for (p = 0; p < 3; p++) begin : g_acc
      assign rd_tot[p] = req.rd && req.addr == OFF_TOTAL_ACTIVE_ENERGY + 16'(p);
      assign rd_fnd[p] = req.rd && req.addr == OFF_FUND_ACTIVE_ENERGY + 16'(p);
      always_ff @(posedge core_clk) begin
        if (srst) begin
          acc_tot_reg[p] <= '0;
          acc_fnd_reg[p] <= '0;
          out_tot_reg[p] <= '0;
          out_fnd_reg[p] <= '0;
        end else begin
          if (lc_latch) begin
            out_tot_reg[p] <= acc_tot_reg[p];
            out_fnd_reg[p] <= acc_fnd_reg[p];
            acc_tot_reg[p] <= acc_tick ? ACC_W'(act_pow[p]) : '0;
            acc_fnd_reg[p] <= acc_tick ? ACC_W'(act_pow[p]) : '0;
          end else begin
            if (rd_tot[p] && clear_on_read) begin
              acc_tot_reg[p] <= '0;
            end else if (acc_tick) begin
              acc_tot_reg[p] <= acc_tot_reg[p] + ACC_W'(act_pow[p]);
            end
            if (rd_fnd[p] && clear_on_read) begin
              acc_fnd_reg[p] <= '0;
            end else if (acc_tick) begin
              acc_fnd_reg[p] <= acc_fnd_reg[p] + ACC_W'(act_pow[p]);
            end
            if (!line_active_enable && rd_tot[p]) out_tot_reg[p] <= acc_tot_reg[p];
            if (!line_active_enable && rd_fnd[p]) out_fnd_reg[p] <= acc_fnd_reg[p];
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Completion flag and interrupt
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cycle_done_flag_reg <= 1'b0;
    end else if (lc_latch) begin
      cycle_done_flag_reg <= 1'b1;
    end else if (wr_sts && req.wdata[CYCLE_DONE_BIT]) begin
      cycle_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      interrupt_pin_0_n <= 1'b1;
    end else begin
      interrupt_pin_0_n <= !(cycle_done_flag_reg && first_interrupt_mask_reg[CYCLE_DONE_BIT]);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [31:0] rd_next;
  logic [15:0] rd_addr_reg;
  logic        rd_pend_reg;
  logic [31:0] rd_hold_reg;
  logic        cal_hit_reg;

  function automatic logic [31:0] pack_ofs(input logic [23:0] v);
    pack_ofs = {4'h0, {4{v[23]}}, v};
  endfunction

  always_comb begin
    rd_next = 32'h0000_0000;
    case (req.addr)
      OFF_HALF_CYCLE_COUNT:  rd_next = {16'h0000, half_cycle_count_reg};
      OFF_COMPENSATION_MODE: rd_next = {16'h0000, compensation_mode_reg};
      OFF_CYCLE_ACCUM_MODE:  rd_next = {24'h00_0000, cycle_accumulation_mode_reg};
      OFF_FIRST_MASK:        rd_next = {16'h0000, first_interrupt_mask_reg};
      OFF_ACCUM_MODE:        rd_next = {16'h0000, accum_mode_reg};
      OFF_FIRST_STATUS:      rd_next = 32'(cycle_done_flag_reg) << CYCLE_DONE_BIT;
      OFF_PHASE_A_INST_VAR:  rd_next = 32'(unsigned'(inst_var[0]));
      OFF_PHASE_B_INST_VAR:  rd_next = 32'(unsigned'(inst_var[1]));
      OFF_PHASE_C_INST_VAR:  rd_next = 32'(unsigned'(inst_var[2]));
      default:               rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata       <= 32'h0000_0000;
      rvalid      <= 1'b0;
      rd_addr_reg <= 16'h0000;
      rd_pend_reg <= 1'b0;
      cal_hit_reg <= 1'b0;
    end else begin
      rd_pend_reg <= req.rd;
      cal_hit_reg <= cal_hit;
      rd_addr_reg <= req.addr;
      rvalid      <= rd_pend_reg;
      if (rd_pend_reg) begin
        if (rd_addr_reg >= OFF_TOTAL_ACTIVE_ENERGY && rd_addr_reg < OFF_TOTAL_ACTIVE_ENERGY + 16'h0003) begin
          rdata <= out_tot_reg[2'(rd_addr_reg - OFF_TOTAL_ACTIVE_ENERGY)];
        end else if (rd_addr_reg >= OFF_FUND_ACTIVE_ENERGY && rd_addr_reg < OFF_FUND_ACTIVE_ENERGY + 16'h0003) begin
          rdata <= out_fnd_reg[2'(rd_addr_reg - OFF_FUND_ACTIVE_ENERGY)];
        end else if (cal_hit_reg) begin
          rdata <= pack_ofs(cal_rdata);
        end else begin
          rdata <= rd_hold_reg;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_hold_reg <= 32'h0000_0000;
    end else begin
      rd_hold_reg <= rd_next;
    end
  end

endmodule // lcre_line_cycle

// [testbench/lcre_properties.sv]
`timescale 1ns/100ps
module lcre_properties
  import lcre_pkg::*;
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        srst,
  // Watched ports.
  input wire lcre_req_t   req,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire lcre_phase_t phase_a,
  input wire lcre_phase_t phase_b,
  input wire lcre_phase_t phase_c,
  input wire logic [23:0] line_ac_rms,
  input wire logic [23:0] phase_b_rms_in,
  input wire logic [23:0] phase_b_voltage_rms,
  input wire logic        interrupt_pin_0_n
);
  // ----
  // Checks.
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic three_w_reg;
  wire  quiet = !(phase_a.zero_cross || phase_b.zero_cross || phase_c.zero_cross);
  wire  clr_w = req.wr && req.addr == OFF_FIRST_STATUS && req.wdata[CYCLE_DONE_BIT];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      three_w_reg <= 1'b0;
    end else if (req.wr && req.addr == OFF_ACCUM_MODE) begin
      three_w_reg <= req.wdata[CONSUMPTION_SEL_LSB +: 2] == CONSUMPTION_SELECT_3WIRE;
    end
  end
  sequence clear_seq; quiet[*3] ##0 clr_w ##1 quiet[*3]; endsequence
  sequence read_seq; req.rd ##2 rvalid; endsequence
  read_answer_a: assert property (req.rd |-> read_seq) else $error("read not answered");
  answer_cause_a: assert property (rvalid |-> $past(req.rd, 2)) else $error("stray answer");
  data_hold_a: assert property (!rvalid |-> $stable(rdata)) else $error("read data moved");
  reset_state_a: assert property ($fell(srst) |-> interrupt_pin_0_n && !rvalid && rdata == 0)
    else $error("bad reset state");
  rms_source_a: assert property (phase_b_voltage_rms == (three_w_reg ? line_ac_rms : phase_b_rms_in))
    else $error("bad rms source");
  unmapped_zero_a: assert property (req.rd && req.addr[15:8] == 8'h00 |-> ##2 rdata == 0)
    else $error("unmapped read not zero");
  irq_release_a: assert property ($rose(interrupt_pin_0_n) |-> $past(req.wr) || $past(req.wr, 2))
    else $error("interrupt released without write");
  flag_clear_a: assert property (clear_seq |-> interrupt_pin_0_n) else $error("interrupt not released");
endmodule // lcre_properties

bind lcre_line_cycle lcre_properties u_props (.core_clk, .srst, .req, .rdata, .rvalid, .phase_a, .phase_b,
  .phase_c, .line_ac_rms, .phase_b_rms_in, .phase_b_voltage_rms, .interrupt_pin_0_n);

// [testbench/tb_lcre_line_cycle.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_lcre_line_cycle;
  import lcre_pkg::*;
  // ----
  // Stimulus and tasks.
  // ----
  localparam lcre_phase_t P0 = '{24'sh20_0000, 24'sh10_0000, 24'sh08_0000, 1'b0};
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  lcre_req_t   req = '0;
  lcre_phase_t phase_a = P0;
  lcre_phase_t phase_b = P0;
  lcre_phase_t phase_c = P0;
  logic [23:0] line_ac_rms = 24'h12_3456;
  logic [23:0] phase_b_rms_in = 24'h65_4321;
  logic [23:0] phase_b_voltage_rms;
  logic [31:0] rdata;
  logic [31:0] rd_v;
  logic [31:0] w;
  logic [23:0] v;
  logic        rvalid;
  logic        interrupt_pin_0_n;
  int          n_errors = 0;
  int          checks = 0;
  logic [15:0] cal [9] = '{OFF_PHASE_A_POWER_GAIN, OFF_PHASE_B_POWER_GAIN, OFF_PHASE_C_POWER_GAIN,
    OFF_PHASE_A_TOTAL_VAR_OFS, OFF_PHASE_B_TOTAL_VAR_OFS, OFF_PHASE_C_TOTAL_VAR_OFS,
    OFF_PHASE_A_FUND_VAR_OFS, OFF_PHASE_B_FUND_VAR_OFS, OFF_PHASE_C_FUND_VAR_OFS};
  always #50 core_clk = ~core_clk;
  lcre_line_cycle DUT (.core_clk, .srst, .req, .rdata, .rvalid, .phase_a, .phase_b, .phase_c,
    .line_ac_rms, .phase_b_rms_in, .phase_b_voltage_rms, .interrupt_pin_0_n);
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    int i;
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge core_clk);
    req.rd <= 1'b0;
    for (i = 0; i < 8 && rvalid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    d = rdata;
    if (i == 8) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic chkrd(input string nm, input logic [15:0] a, input logic [31:0] e);
    rd(a, rd_v);
    `CHK(nm, e, rd_v)
  endtask
  task automatic st(input logic f, input logic irq);
    rd(OFF_FIRST_STATUS, rd_v);
    `CHK("done flag", f, rd_v[CYCLE_DONE_BIT])
    `CHK("irq pin", irq, interrupt_pin_0_n)
  endtask
  task automatic zx(input int p, input int n);
    repeat (n) begin
      @(posedge core_clk);
      phase_a.zero_cross <= (p == 0);
      phase_b.zero_cross <= (p == 1);
      phase_c.zero_cross <= (p == 2);
      @(posedge core_clk);
      phase_a.zero_cross <= 1'b0;
      phase_b.zero_cross <= 1'b0;
      phase_c.zero_cross <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    chkrd("count", OFF_HALF_CYCLE_COUNT, {16'h0000, RST_HALF_CYCLE_COUNT});
    chkrd("mode", OFF_CYCLE_ACCUM_MODE, {24'h00_0000, RST_CYCLE_ACCUM_MODE});
    `CHK("rms 4w", phase_b_rms_in, phase_b_voltage_rms)
    wr(OFF_ACCUM_MODE, 32'h0000_0010);
    wr(OFF_COMPENSATION_MODE, 32'h0000_016D);
    chkrd("comp mode", OFF_COMPENSATION_MODE, 32'h0000_016D);
    repeat (40) @(posedge core_clk);
    `CHK("rms 3w", line_ac_rms, phase_b_voltage_rms)
    chkrd("b var", OFF_PHASE_B_INST_VAR, 32'h0000_0000);
    chkrd("unmapped", 16'h0012, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      v = {(i[0] ? 4'hC : 4'h3), 20'h5_A5A0 + 20'(i)};
      w = {4'h0, {4{v[23]}}, v};
      wr(cal[i], w);
      chkrd("cal", cal[i], w);
    end
    wr(OFF_ACCUM_MODE, 32'h0000_0000);
    wr(OFF_FIRST_MASK, 32'h0000_0020);
    wr(OFF_CYCLE_ACCUM_MODE, 32'h0000_0009);
    wr(OFF_HALF_CYCLE_COUNT, 32'h0000_0003);
    wr(OFF_FIRST_STATUS, 32'h0000_0020);
    zx(1, 4);
    zx(0, 2);
    st(1'b0, 1'b1);
    zx(0, 1);
    st(1'b1, 1'b0);
    rd(OFF_TOTAL_ACTIVE_ENERGY, w);
    chkrd("energy hold", OFF_TOTAL_ACTIVE_ENERGY, w);
    wr(OFF_FIRST_STATUS, 32'h0000_0020);
    st(1'b0, 1'b1);
    zx(0, 2);
    wr(OFF_HALF_CYCLE_COUNT, 32'h0000_0003);
    zx(0, 2);
    st(1'b0, 1'b1);
    zx(0, 1);
    st(1'b1, 1'b0);
    wr(OFF_FIRST_MASK, 32'h0000_0000);
    wr(OFF_FIRST_STATUS, 32'h0000_0020);
    zx(0, 3);
    st(1'b1, 1'b1);
    end_of_test();
  end
endmodule // tb_lcre_line_cycle
